//--- src/tcmp_defines.svh
/*
   Register offsets, field positions, reset values and divider counts of the
   timer output compare block.
   Assumes: included by bare name from the package and from the design file.
*/
`ifndef TCMP_DEFINES_SVH
`define TCMP_DEFINES_SVH

// register indexes on the plain register port
`define TCMP_ADDR_CTRL_A 4'h0
`define TCMP_ADDR_CTRL_B 4'h1
`define TCMP_ADDR_COUNTER 4'h2
`define TCMP_ADDR_CMP0 4'h3
`define TCMP_ADDR_CMP1 4'h4
`define TCMP_ADDR_WAVE_CTRL 4'h5
`define TCMP_ADDR_PORT_DATA 4'h6
`define TCMP_ADDR_STATUS 4'h7

// control_word_a fields
`define TCMP_A_RUN 0
`define TCMP_A_CLK_LO 1
`define TCMP_A_CLK_HI 2

// control_word_b fields
`define TCMP_B_CLEAR 2
`define TCMP_B_MODE 3
`define TCMP_B_LVL0_LO 4
`define TCMP_B_LVL0_HI 5
`define TCMP_B_LVL1_LO 6
`define TCMP_B_LVL1_HI 7

// waveform_out_control fields
`define TCMP_W_EN_HI 5
`define TCMP_W_INV0 6
`define TCMP_W_INV1 7

// status fields
`define TCMP_S_RUN 0
`define TCMP_S_PEND0 1
`define TCMP_S_PEND1 2
`define TCMP_S_WAVE0 3
`define TCMP_S_WAVE1 4

// reset values
`define TCMP_RST_BYTE 8'h00
`define TCMP_RST_WORD 16'h0000

// prescaler: divide by 8 and by 32
`define TCMP_DIV8_MASK 5'h07
`define TCMP_DIV32_MASK 5'h1f

`endif

//--- src/tcmp_pkg.sv
/*
   Types shared by the timer output compare block.
   Assumes: tcmp_defines.svh is on the include path.
*/
`default_nettype none
`include "tcmp_defines.svh"

package tcmp_pkg;

   // one register port request, sampled on the rising edge of sys_clk
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } tcmp_bus_req_t;

   // count source select in control_word_a
   typedef enum logic [1:0] {
      TCMP_CLK_F1 = 2'h0,
      TCMP_CLK_DIV8 = 2'h1,
      TCMP_CLK_DIV32 = 2'h2,
      TCMP_CLK_RING = 2'h3
   } tcmp_clk_sel_t;

   // level applied to a compare waveform at its compare event
   typedef enum logic [1:0] {
      TCMP_LVL_KEEP = 2'h0,
      TCMP_LVL_LOW = 2'h1,
      TCMP_LVL_HIGH = 2'h2,
      TCMP_LVL_TOGGLE = 2'h3
   } tcmp_level_t;

   // compare event flags produced in one count tick
   typedef struct packed {
      logic ovf;
      logic cmp1;
      logic cmp0;
   } tcmp_events_t;

endpackage : tcmp_pkg

`default_nettype wire

//--- src/tcmp_timer.sv
/*
   Output compare timer: 16-bit up counter with four count sources, two
   buffered compare circuits, overflow and compare event pulses, and six
   compare waveform pins.
   Assumes: one 10 MHz sys_clk, async active-low rst_b, a register master on
   the plain port that never strobes read and write together, and a fast
   ring oscillator arriving from another clock domain.
*/
// The plain strobed port and the address map were left to the implementer.
// Behaviour
// - counter source: undivided, divide by 8, divide by 32, or fast ring oscillator
// - counter increments on each source tick while running; zero while stopped
// - writing run bit one starts counting
// - writing run bit zero halts counting and clears counter
// - a pin carries compare waveform only while its enable bit is one
// - clearing a pin's enable bit stops the compare waveform on that pin
// - counter equal to compare value 0 raises first compare event
// - counter equal to compare value 1 raises second compare event
// - counter overflow raises a separate overflow event
// - reading a compare value register returns the active compare value
// - reading main counter returns the live count
// - writes to the main counter are ignored
// - while stopped, compare value writes take effect at once
// - running free-run, pending compare writes transfer at overflow
// - running with clear bit, pending compare writes transfer on compare 1 match
// - with clear bit set counter returns to zero on compare 1 match
// - two-bit field sets waveform level at compare 0 event
// - two invert bits optionally invert the compare waveforms
// - pin shows waveform when port data bit is one, fixed level otherwise
// - compare function active when mode select bit is one
`default_nettype none
`include "tcmp_defines.svh"

module tcmp_timer
   import tcmp_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int N_PINS = 6
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire tcmp_bus_req_t bus_req,
   output logic [15:0] rd_data,
   input wire logic ring_osc_in,
   output logic [N_PINS-1:0] cmp_pin,
   output logic [N_PINS-1:0] cmp_pin_sel,
   output tcmp_events_t irq_pulse
);

   localparam int HALF = N_PINS / 2;

   generate
      if (CNT_W != 16 || N_PINS != 6)
      begin : g_check
         $error("tcmp_timer supports only a 16-bit counter and six pins");
      end
   endgenerate

   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] wave_ctrl_q;
   logic [N_PINS-1:0] port_data_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cmp0_q;
   logic [CNT_W-1:0] cmp1_q;
   logic [CNT_W-1:0] hold0_q;
   logic [CNT_W-1:0] hold1_q;
   logic pend0_q;
   logic pend1_q;
   logic wave0_q;
   logic wave1_q;
   logic [4:0] presc_q;
   logic ring_meta_q;
   logic ring_sync_q;
   logic ring_prev_q;
   logic tick;
   logic run;
   logic mode;
   logic clear_mode;
   logic match0;
   logic match1;
   logic ovf;
   logic xfer;
   logic wr_cmp0;
   logic wr_cmp1;
   tcmp_clk_sel_t clk_sel;

   assign run = ctrl_a_q[`TCMP_A_RUN];
   assign clk_sel = tcmp_clk_sel_t'(ctrl_a_q[`TCMP_A_CLK_HI:`TCMP_A_CLK_LO]);
   assign clear_mode = ctrl_b_q[`TCMP_B_CLEAR];
   assign mode = ctrl_b_q[`TCMP_B_MODE];
   assign wr_cmp0 = bus_req.wr && bus_req.addr == `TCMP_ADDR_CMP0;
   assign wr_cmp1 = bus_req.wr && bus_req.addr == `TCMP_ADDR_CMP1;

   // ---------------- count sources ----------------
   // free-running prescaler so a started count sees an unbiased first tick phase
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         presc_q <= 5'h00;
      else
         presc_q <= presc_q + 5'h01;
   end

   // ring oscillator is asynchronous: two flops, then edge detect on the second
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ring_meta_q <= 1'b0;
         ring_sync_q <= 1'b0;
         ring_prev_q <= 1'b0;
      end
      else
      begin
         ring_meta_q <= ring_osc_in;
         ring_sync_q <= ring_meta_q;
         ring_prev_q <= ring_sync_q;
      end
   end

   // ring ticks are lost above half of sys_clk; a limitation of sampling it
   always_comb
   begin
      unique case (clk_sel)
         TCMP_CLK_F1: tick = 1'b1;
         TCMP_CLK_DIV8: tick = (presc_q & `TCMP_DIV8_MASK) == `TCMP_DIV8_MASK;
         TCMP_CLK_DIV32: tick = presc_q == `TCMP_DIV32_MASK;
         TCMP_CLK_RING: tick = ring_sync_q && !ring_prev_q;
      endcase
   end

   // ---------------- compare and overflow detection ----------------
   assign match0 = run && tick && mode && cnt_q == cmp0_q;
   assign match1 = run && tick && mode && cnt_q == cmp1_q;
   assign ovf = run && tick && (&cnt_q) && !(clear_mode && match1);
   assign xfer = clear_mode ? match1 : ovf;

   // ---------------- control registers ----------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_a_q <= `TCMP_RST_BYTE;
         ctrl_b_q <= `TCMP_RST_BYTE;
         wave_ctrl_q <= `TCMP_RST_BYTE;
         port_data_q <= '0;
      end
      else if (bus_req.wr)
      begin
         unique case (bus_req.addr)
            `TCMP_ADDR_CTRL_A: ctrl_a_q <= bus_req.wdata[7:0];
            `TCMP_ADDR_CTRL_B: ctrl_b_q <= bus_req.wdata[7:0];
            `TCMP_ADDR_WAVE_CTRL: wave_ctrl_q <= bus_req.wdata[7:0];
            `TCMP_ADDR_PORT_DATA: port_data_q <= bus_req.wdata[N_PINS-1:0];
            default: ;
         endcase
      end
   end

   // ---------------- counter ----------------
   // no bus path reaches cnt_q, so counter writes fall away
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_q <= `TCMP_RST_WORD;
      else if (!run)
         cnt_q <= `TCMP_RST_WORD;
      else if (clear_mode && match1)
         cnt_q <= `TCMP_RST_WORD;
      else if (tick)
         cnt_q <= cnt_q + 16'h0001;
   end

   // ---------------- compare buffering ----------------
   // a write landing in the transfer cycle stays pending for the next one
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hold0_q <= `TCMP_RST_WORD;
         pend0_q <= 1'b0;
         cmp0_q <= `TCMP_RST_WORD;
      end
      else if (wr_cmp0 && !run)
      begin
         hold0_q <= bus_req.wdata;
         cmp0_q <= bus_req.wdata;
         pend0_q <= 1'b0;
      end
      else if (wr_cmp0)
      begin
         hold0_q <= bus_req.wdata;
         pend0_q <= 1'b1;
      end
      else if (xfer)
      begin
         cmp0_q <= hold0_q;
         pend0_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hold1_q <= `TCMP_RST_WORD;
         pend1_q <= 1'b0;
         cmp1_q <= `TCMP_RST_WORD;
      end
      else if (wr_cmp1 && !run)
      begin
         hold1_q <= bus_req.wdata;
         cmp1_q <= bus_req.wdata;
         pend1_q <= 1'b0;
      end
      else if (wr_cmp1)
      begin
         hold1_q <= bus_req.wdata;
         pend1_q <= 1'b1;
      end
      else if (xfer)
      begin
         cmp1_q <= hold1_q;
         pend1_q <= 1'b0;
      end
   end

   // ---------------- event pulses ----------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         irq_pulse <= '0;
      else
      begin
         irq_pulse.cmp0 <= match0;
         irq_pulse.cmp1 <= match1;
         irq_pulse.ovf <= ovf;
      end
   end

   // ---------------- waveforms ----------------
   function automatic logic next_level(input logic cur, input tcmp_level_t sel);
      logic res;
      res = cur;
      unique case (sel)
         TCMP_LVL_KEEP: res = cur;
         TCMP_LVL_LOW: res = 1'b0;
         TCMP_LVL_HIGH: res = 1'b1;
         TCMP_LVL_TOGGLE: res = !cur;
      endcase
      return res;
   endfunction

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wave0_q <= 1'b0;
         wave1_q <= 1'b0;
      end
      else
      begin
         if (match0)
            wave0_q <= next_level(wave0_q,
               tcmp_level_t'(ctrl_b_q[`TCMP_B_LVL0_HI:`TCMP_B_LVL0_LO]));
         if (match1)
            wave1_q <= next_level(wave1_q,
               tcmp_level_t'(ctrl_b_q[`TCMP_B_LVL1_HI:`TCMP_B_LVL1_LO]));
      end
   end

   // pins 0..2 follow compare 0, pins 3..5 follow compare 1
   genvar gi;
   generate
      for (gi = 0; gi < N_PINS; gi++)
      begin : g_pin
         logic wave;
         assign wave = (gi < HALF) ? wave0_q ^ wave_ctrl_q[`TCMP_W_INV0]
                                   : wave1_q ^ wave_ctrl_q[`TCMP_W_INV1];
         always_ff @(posedge sys_clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               cmp_pin[gi] <= 1'b0;
               cmp_pin_sel[gi] <= 1'b0;
            end
            else
            begin
               cmp_pin_sel[gi] <= wave_ctrl_q[gi] && mode;
               if (wave_ctrl_q[gi] && mode)
                  cmp_pin[gi] <= port_data_q[gi] ? wave : 1'b0;
               else
                  cmp_pin[gi] <= port_data_q[gi];
            end
         end
      end
   endgenerate

   // ---------------- register reads ----------------
   // reads are whole words only, so the counter cannot tear between bytes
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_data <= `TCMP_RST_WORD;
      else if (!bus_req.rd)
         rd_data <= `TCMP_RST_WORD;
      else
      begin
         unique case (bus_req.addr)
            `TCMP_ADDR_CTRL_A: rd_data <= {8'h00, ctrl_a_q};
            `TCMP_ADDR_CTRL_B: rd_data <= {8'h00, ctrl_b_q};
            `TCMP_ADDR_COUNTER: rd_data <= cnt_q;
            `TCMP_ADDR_CMP0: rd_data <= cmp0_q;
            `TCMP_ADDR_CMP1: rd_data <= cmp1_q;
            `TCMP_ADDR_WAVE_CTRL: rd_data <= {8'h00, wave_ctrl_q};
            `TCMP_ADDR_PORT_DATA: rd_data <= {10'h000, port_data_q};
            `TCMP_ADDR_STATUS: rd_data <= {11'h000, wave1_q, wave0_q, pend1_q, pend0_q, run};
            default: rd_data <= `TCMP_RST_WORD;
         endcase
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   chk_stop_clears_cnt: assert property (
      !run |=> cnt_q == 16'h0000)
      else $error("counter not zero while stopped");

   chk_cnt_increments: assert property (
      run && tick && !(clear_mode && match1) |=> cnt_q == $past(cnt_q) + 16'h0001 || !$past(run))
      else $error("counter did not advance on tick");

   chk_cnt_holds: assert property (
      run && !tick |=> cnt_q == $past(cnt_q))
      else $error("counter moved without tick");

   chk_cmp0_event: assert property (
      run && tick && mode && cnt_q == cmp0_q |=> irq_pulse.cmp0 ##1 !irq_pulse.cmp0 || $past(match0))
      else $error("compare 0 event missing");

   chk_cmp1_clear: assert property (
      run && tick && mode && clear_mode && cnt_q == cmp1_q |=> irq_pulse.cmp1 && cnt_q == 16'h0000)
      else $error("compare 1 match did not clear counter");

   chk_ovf_wrap: assert property (
      run && tick && cnt_q == 16'hffff && !clear_mode |=> irq_pulse.ovf && cnt_q == 16'h0000)
      else $error("overflow did not wrap and signal");

   chk_stopped_load: assert property (
      wr_cmp0 && !run |=> cmp0_q == $past(bus_req.wdata))
      else $error("stopped compare write not immediate");

   chk_running_hold: assert property (
      wr_cmp1 && run && !xfer |=> cmp1_q == $past(cmp1_q) && pend1_q)
      else $error("running compare write bypassed holding register");

   chk_freerun_xfer: assert property (
      xfer && !clear_mode && !wr_cmp0 |=> cmp0_q == $past(hold0_q))
      else $error("overflow transfer missing");

   chk_pin_disabled: assert property (
      !wave_ctrl_q[0] |=> cmp_pin[0] == $past(port_data_q[0]) && !cmp_pin_sel[0])
      else $error("disabled pin still carries waveform");

   chk_read_counter: assert property (
      bus_req.rd && bus_req.addr == `TCMP_ADDR_COUNTER |=> rd_data == $past(cnt_q))
      else $error("counter read mismatch");

endmodule : tcmp_timer

`default_nettype wire

//--- test/tcmp_timer_tb.sv
/*
   Self-checking testbench of the output compare timer: register tasks on
   the plain port, event counters on the pulse outputs, scenario sequence.
   Assumes: tcmp_pkg and tcmp_defines.svh compiled ahead; the compare
   assertions live inside the design itself.
*/
`default_nettype none
`include "tcmp_defines.svh"

`define CHK(got, exp) \
   begin \
      compares++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("FAIL t=%0t got %h exp %h", $time, got, exp); \
      end \
   end

module tcmp_timer_tb
   import tcmp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ring_osc_in = 1'b0;
   logic ring_on = 1'b0;
   tcmp_bus_req_t req = '0;
   logic [15:0] rd_data;
   logic [5:0] cmp_pin;
   logic [5:0] cmp_pin_sel;
   tcmp_events_t irq_pulse;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   int n_cmp0 = 0;
   int n_cmp1 = 0;
   int n_ovf = 0;
   int keep;
   logic [15:0] v;

   tcmp_timer u_tcmp_timer (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .bus_req(req),
      .rd_data(rd_data),
      .ring_osc_in(ring_osc_in),
      .cmp_pin(cmp_pin),
      .cmp_pin_sel(cmp_pin_sel),
      .irq_pulse(irq_pulse)
   );

   always #50 sys_clk = ~sys_clk;

   // ring period 300 ns; toggles sit 25 ns off every sys_clk rising edge to avoid races
   initial
   begin
      #25;
      forever
      begin
         #150;
         if (ring_on)
            ring_osc_in = ~ring_osc_in;
      end
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (irq_pulse.cmp0 === 1'b1) n_cmp0++;
      if (irq_pulse.cmp1 === 1'b1) n_cmp1++;
      if (irq_pulse.ovf === 1'b1) n_ovf++;
      // one full free-run wrap is about 66k cycles, the rest is small
      if (cycles == 90000)
      begin
         err_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (err_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      req <= '0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge sys_clk);
      req <= '0;
      @(negedge sys_clk);
      d = rd_data;
   endtask

   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      `CHK(d, exp)
   endtask

   // pins are registered behind the wave register: let both land
   task automatic pins(input logic [5:0] exp_pin, input logic [5:0] exp_sel);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(cmp_pin, exp_pin)
      `CHK(cmp_pin_sel, exp_sel)
   endtask

   initial
   begin
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      rchk(`TCMP_ADDR_CTRL_A, 16'h0000);
      rchk(`TCMP_ADDR_CTRL_B, 16'h0000);
      rchk(`TCMP_ADDR_WAVE_CTRL, 16'h0000);
      rchk(`TCMP_ADDR_COUNTER, 16'h0000);
      // stopped: compare writes land at once
      wr(`TCMP_ADDR_CMP0, 16'h0002);
      rchk(`TCMP_ADDR_CMP0, 16'h0002);
      wr(`TCMP_ADDR_CMP1, 16'h0005);
      rchk(`TCMP_ADDR_CMP1, 16'h0005);
      wr(`TCMP_ADDR_COUNTER, 16'h1234);
      rchk(`TCMP_ADDR_COUNTER, 16'h0000);
      rchk(4'h9, 16'h0000);
      wr(`TCMP_ADDR_WAVE_CTRL, 16'hffff);
      rchk(`TCMP_ADDR_WAVE_CTRL, 16'h00ff);
      wr(`TCMP_ADDR_WAVE_CTRL, 16'h003f);
      wr(`TCMP_ADDR_PORT_DATA, 16'h003f);
      // mode on, level0 toggle, level1 high, free-run
      wr(`TCMP_ADDR_CTRL_B, 16'h00b8);
      pins(6'h00, 6'h3f);
      wr(`TCMP_ADDR_CTRL_A, 16'h0001);
      rchk(`TCMP_ADDR_COUNTER, 16'h0001);
      repeat (20) @(posedge sys_clk);
      `CHK(n_cmp0, 1)
      `CHK(n_cmp1, 1)
      `CHK(n_ovf, 0)
      pins(6'h3f, 6'h3f);
      wr(`TCMP_ADDR_WAVE_CTRL, 16'h007f);
      pins(6'h38, 6'h3f);
      wr(`TCMP_ADDR_WAVE_CTRL, 16'h00bf);
      pins(6'h07, 6'h3f);
      wr(`TCMP_ADDR_PORT_DATA, 16'h0038);
      pins(6'h00, 6'h3f);
      wr(`TCMP_ADDR_PORT_DATA, 16'h0005);
      wr(`TCMP_ADDR_WAVE_CTRL, 16'h0000);
      pins(6'h05, 6'h00);
      // running: the write waits for the wrap
      wr(`TCMP_ADDR_CMP0, 16'h0007);
      rchk(`TCMP_ADDR_CMP0, 16'h0002);
      rchk(`TCMP_ADDR_STATUS, 16'h001b);
      repeat (65560) @(posedge sys_clk);
      `CHK(n_ovf, 1)
      rchk(`TCMP_ADDR_CMP0, 16'h0007);
      wr(`TCMP_ADDR_CTRL_A, 16'h0000);
      rchk(`TCMP_ADDR_COUNTER, 16'h0000);
      // clear on second compare: period of cmp1 + 1
      wr(`TCMP_ADDR_CMP1, 16'h0009);
      wr(`TCMP_ADDR_CTRL_B, 16'h00bc);
      wr(`TCMP_ADDR_CTRL_A, 16'h0001);
      wr(`TCMP_ADDR_CMP1, 16'h0004);
      rchk(`TCMP_ADDR_CMP1, 16'h0009);
      keep = n_ovf;
      repeat (40) @(posedge sys_clk);
      rchk(`TCMP_ADDR_CMP1, 16'h0004);
      rd(`TCMP_ADDR_COUNTER, v);
      `CHK(v <= 16'h0004, 1'b1)
      `CHK(n_ovf, keep)
      // divided and ring sources, mode off so no compare events
      wr(`TCMP_ADDR_CTRL_A, 16'h0000);
      wr(`TCMP_ADDR_CTRL_B, 16'h0000);
      ring_on = 1'b1;
      keep = n_cmp0;
      for (int i = 1; i < 4; i++)
      begin
         wr(`TCMP_ADDR_CTRL_A, 16'(2 * i));
         wr(`TCMP_ADDR_CTRL_A, 16'(2 * i + 1));
         repeat (i == 1 ? 80 : (i == 2 ? 320 : 60)) @(posedge sys_clk);
         rd(`TCMP_ADDR_COUNTER, v);
         `CHK(v inside {[16'h0009 : 16'h000b]} || (i == 3 && v inside {[16'h0012 : 16'h0015]}),
            1'b1)
         wr(`TCMP_ADDR_COUNTER, 16'hffff);
         wr(`TCMP_ADDR_CTRL_A, 16'(2 * i));
      end
      `CHK(n_cmp0, keep)
      complete_run();
   end

endmodule // tcmp_timer_tb

`default_nettype wire
